// file: core/pc_stack_indirect_addr.sv
// Overview of operation
// RL1: counter advances by one each plain instruction
// RL2: jump loads all nine counter bits
// RL3: call or low-byte write clears bit 8
// RL4: low-byte file location aliases counter bits 7:0
// RL5: reset sets all ones, then wraps zero
// RL6: two stack entries, eight or nine bits
// RL7: call shifts level one down, pushes return
// RL8: return pops level one, level two stays
// RL9: return loads literal into accumulator
// RL10: no overflow or underflow flags at all
// RL11: indirect port accesses location held in pointer
// RL12: indirect read with zero pointer returns zero
// RL13: indirect write with zero pointer stores nothing
// RL14: pointer has five bits, locations 00h-1Fh
// RL15: pointer bits 7:5 read back ones
// RL16: pointer ignores high write bits, wraps
`timescale 1ns/1ps
`default_nettype none
module pc_stack_indirect_addr
  import pc_stack_pkg::*;
(
  input  wire logic        clk_in,              // 125 mhz core clock
  input  wire logic        rst_in,              // sync, active high
  input  wire logic        step_in,             // one instruction executes
  input  wire instr_t      instr_in,            // decoded instruction
  input  wire file_req_t   file_in,             // data file access
  output logic      [7:0]  file_rdata_out,      // file read, next cycle
  output logic      [8:0]  pc_out,              // program counter
  output logic      [7:0]  acc_out,             // working accumulator
  input  wire logic [4:0]  avs_address_in,      // byte address
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out
);

  logic [8:0]  pc;                 // program counter
  logic [8:0]  stk1;               // stack level one
  logic [8:0]  stk2;               // stack level two
  logic [7:0]  acc;                // accumulator
  logic [4:0]  ptr;                // indirect_pointer, five bits
  logic        wide;               // nine-bit stack variant
  logic [7:0]  ram [0:31];         // data file cells
  logic [7:0]  rdata;              // registered file read
  bus_st_t     bus_st;             // bus slave state
  logic [31:0] rd_word;            // registered bus read
  logic [4:0]  eff;                // effective file address
  logic        wr_go;              // file write this step
  logic        low_wr;             // computed jump
  logic        ptr_wr;             // pointer written by file
  logic        bus_take;           // bus request accepted
  logic        bus_wr;             // bus write accepted
  logic [8:0]  next_pc;            // counter for this step
  logic [8:0]  ret_addr;           // pushed return address

  // resolve an indirect address through the pointer
  function automatic logic [4:0] resolve(input logic [4:0] a, input logic [4:0] p);
    resolve = (a == FILE_IND) ? p : a; // RL11
  endfunction

  // trim a return address to the stack width
  function automatic logic [8:0] trim(input logic [8:0] a, input logic w);
    trim = w ? a : (a & HI_MASK); // RL6
  endfunction

  // file write decode, qualified by the step strobe
  always_comb begin
    eff    = resolve(file_in.addr, ptr);
    wr_go  = step_in && file_in.wr && (eff != FILE_IND); // RL13
    // a write landing on the low byte is a computed jump
    low_wr = wr_go && (eff == FILE_LOW);
    // a write landing on the pointer reloads it
    ptr_wr = wr_go && (eff == FILE_PTR);
  end

  // next counter value, low-byte write wins over branch
  always_comb begin
    ret_addr = trim(pc + PC_ONE, wide);
    // return address always formed from the old counter
    // low-byte write overrides whatever the opcode says
    if (low_wr) begin
      next_pc = {1'b0, file_in.wdata}; // RL3 RL4
    end else begin
      case (instr_in.op)
        OP_JUMP:  next_pc = instr_in.addr; // RL2
        OP_CALL:  next_pc = {1'b0, instr_in.addr[7:0]}; // RL3
        OP_RETURN: next_pc = stk1; // RL8
        // plain step, wraps from all ones to zero
        default:  next_pc = pc + PC_ONE; // RL1 RL5
      endcase
    end
  end

  // program counter
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pc <= PC_RESET; // RL5
    end else if (step_in) begin
      pc <= next_pc;
    end
  end

  // two-level return stack, no overflow tracking
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stk1 <= '0;
      stk2 <= '0;
    end else if (step_in && !low_wr && instr_in.op == OP_CALL) begin
      // push: oldest entry falls off silently
      stk2 <= stk1; // RL7 RL10
      stk1 <= ret_addr; // RL7
    end else if (step_in && !low_wr && instr_in.op == OP_RETURN) begin
      // pop: level two is copied up and also kept
      stk1 <= stk2; // RL8
    end
  end

  // accumulator takes the returned literal
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      acc <= ZERO_BYTE;
    end else if (step_in && instr_in.op == OP_RETURN) begin
      // literal loads even when a low-byte write redirects
      acc <= instr_in.literal; // RL9
    end
  end

  // pointer: file write beats bus write, high bits dropped
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ptr <= PTR_RESET;
    end else if (ptr_wr) begin
      ptr <= file_in.wdata[4:0]; // RL14 RL16
    end else if (bus_wr && avs_address_in == REG_PTR && avs_byteenable_in[0]) begin
      ptr <= avs_writedata_in[4:0]; // RL16
    end
  end

  // stack width configuration
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wide <= CFG_RESET;
    end else if (bus_wr && avs_address_in == REG_CFG && avs_byteenable_in[0]) begin
      wide <= avs_writedata_in[0];
    end
  end

  // plain data cells, one per file location
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_cell
      always_ff @(posedge clk_in) begin
        // special locations keep their own storage elsewhere
        if (wr_go && eff == 5'(gi) && eff != FILE_LOW && eff != FILE_PTR) begin
          ram[gi] <= file_in.wdata; // RL11
        end
      end
    end
  endgenerate

  // file read, special locations first
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata <= ZERO_BYTE;
    end else if (eff == FILE_IND) begin
      rdata <= ZERO_BYTE; // RL12
    end else if (eff == FILE_LOW) begin
      // low byte reads back the live counter
      rdata <= pc[7:0]; // RL4
    end else if (eff == FILE_PTR) begin
      rdata <= {PTR_FILL, ptr}; // RL15
    end else begin
      rdata <= ram[eff];
    end
  end

  // bus slave: one wait cycle, answer on the second
  always_comb begin
    bus_take = (avs_read_in || avs_write_in) && (bus_st == BUS_IDLE);
    bus_wr   = avs_write_in && (bus_st == BUS_DONE);
    avs_waitrequest_out = (avs_read_in || avs_write_in) && (bus_st != BUS_DONE);
  end

  // bus state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bus_st <= BUS_IDLE;
    end else begin
      case (bus_st)
        BUS_IDLE: bus_st <= bus_take ? BUS_DONE : BUS_IDLE;
        BUS_DONE: bus_st <= BUS_IDLE;
        default:  bus_st <= BUS_IDLE;
      endcase
    end
  end

  // read word captured while waitrequest is high
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_word <= '0;
    end else if (bus_take && avs_read_in) begin
      case (avs_address_in)
        REG_PTR:  rd_word <= {24'h000000, PTR_FILL, ptr}; // RL15
        REG_PC:   rd_word <= {23'h000000, pc};
        REG_STK1: rd_word <= {23'h000000, stk1};
        REG_STK2: rd_word <= {23'h000000, stk2};
        REG_ACC:  rd_word <= {24'h000000, acc};
        REG_CFG:  rd_word <= {31'h00000000, wide};
        default:  rd_word <= '0; // unmapped reads zero
      endcase
    end
  end

  // outputs
  assign pc_out           = pc;
  assign acc_out          = acc;
  assign file_rdata_out   = rdata;
  assign avs_readdata_out = rd_word;

  // all checks run on the core clock, quiet during reset
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // counter steps by one on a plain instruction
  chk_pc_advance: assert property (step_in && !low_wr && instr_in.op == OP_SEQ // RL1
    |=> pc == $past(pc) + PC_ONE)
    else $error("counter did not advance");

  // counter holds between instructions
  chk_pc_hold: assert property (!step_in // RL1
    |=> pc == $past(pc))
    else $error("counter moved without a step");

  // jump takes all nine bits from the instruction
  chk_jump_load: assert property (step_in && !low_wr && instr_in.op == OP_JUMP // RL2
    |=> pc == $past(instr_in.addr))
    else $error("jump target wrong");

  // call takes the low byte and clears bit 8
  chk_call_target: assert property (step_in && !low_wr && instr_in.op == OP_CALL // RL3
    |=> pc[8] == 1'b0 && pc[7:0] == $past(instr_in.addr[7:0]))
    else $error("call target wrong");

  // a computed jump leaves the stack alone
  chk_low_nopush: assert property (low_wr // RL3
    |=> stk1 == $past(stk1) && stk2 == $past(stk2))
    else $error("computed jump touched the stack");

  // low-byte write is a jump inside the first page half
  chk_low_alias: assert property (low_wr // RL4
    |=> pc == {1'b0, $past(file_in.wdata)})
    else $error("computed jump wrong");

  // low-byte location reads the counter
  chk_low_read: assert property (file_in.addr == FILE_LOW // RL4
    |=> file_rdata_out == $past(pc[7:0]))
    else $error("low byte read wrong");

  // counter sits at all ones right after reset
  chk_reset_value: assert property ($past(rst_in) && !step_in // RL5
    |=> pc == PC_RESET)
    else $error("counter not all ones after reset");

  // the last word rolls over to zero
  chk_wrap_zero: assert property (step_in && !low_wr && instr_in.op == OP_SEQ && pc == PC_RESET // RL5
    |=> pc == 9'h000)
    else $error("counter did not wrap");

  // narrow stack never keeps bit 8
  chk_narrow_entry: assert property (step_in && !low_wr && instr_in.op == OP_CALL && !wide // RL6
    |=> stk1[8] == 1'b0)
    else $error("narrow entry kept bit 8");

  // push shifts level one down first
  chk_call_push: assert property (step_in && !low_wr && instr_in.op == OP_CALL // RL7
    |=> stk2 == $past(stk1) && stk1 == $past(ret_addr))
    else $error("push order wrong");

  // pop copies level two up and keeps it
  chk_ret_pop: assert property (step_in && !low_wr && instr_in.op == OP_RETURN // RL8
    |=> pc == $past(stk1) && stk1 == $past(stk2) && stk2 == $past(stk2))
    else $error("pop wrong");

  // return loads its literal
  chk_ret_literal: assert property (step_in && instr_in.op == OP_RETURN // RL9
    |=> acc == $past(instr_in.literal))
    else $error("literal not loaded");

  // accumulator moves only on a return
  chk_acc_hold: assert property (!(step_in && instr_in.op == OP_RETURN) // RL9
    |=> acc == $past(acc))
    else $error("accumulator changed");

  // indirect read reaches the pointed plain cell
  chk_ind_read: assert property (file_in.addr == FILE_IND && ptr != FILE_IND && ptr != FILE_LOW && ptr != FILE_PTR // RL11
    |=> file_rdata_out == $past(ram[ptr]))
    else $error("indirect read wrong");

  // indirect self read gives zero
  chk_ind_zero: assert property (file_in.addr == FILE_IND && ptr == FILE_IND // RL12
    |=> file_rdata_out == ZERO_BYTE)
    else $error("indirect self read not zero");

  // indirect self write stores nothing
  chk_ind_nostore: assert property (step_in && file_in.wr && file_in.addr == FILE_IND && ptr == FILE_IND // RL13
    |=> ptr == $past(ptr))
    else $error("indirect self write stored");

  // unimplemented pointer bits read high
  chk_ptr_high: assert property (eff == FILE_PTR // RL15
    |=> file_rdata_out[7:5] == PTR_FILL)
    else $error("pointer high bits not ones");

  // pointer keeps only five written bits
  chk_ptr_five: assert property (ptr_wr // RL16
    |=> ptr == $past(file_in.wdata[4:0]))
    else $error("pointer write wrong");

  // one wait cycle, then the answer
  chk_bus_answer: assert property ((avs_read_in || avs_write_in) && bus_st == BUS_IDLE
    |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("bus answer late");

  // no request, no wait
  chk_bus_idle: assert property (!avs_read_in && !avs_write_in
    |-> !avs_waitrequest_out)
    else $error("wait without request");

  // read data stands until the next read
  chk_rdata_hold: assert property (!(bus_take && avs_read_in)
    |=> avs_readdata_out == $past(avs_readdata_out))
    else $error("read data changed");

endmodule
`default_nettype wire

// file: core/pc_stack_pkg.sv
package pc_stack_pkg;

  // counter and stack geometry
  localparam int unsigned PC_W       = 9;
  localparam logic [8:0]  PC_RESET   = 9'h1ff;  // last program word
  localparam logic [8:0]  PC_ONE     = 9'h001;
  localparam logic [8:0]  HI_MASK    = 9'h0ff;  // narrow stack keeps 7:0

  // data file map (5-bit file address)
  localparam logic [4:0]  FILE_IND   = 5'h00;   // indirect_data_port
  localparam logic [4:0]  FILE_LOW   = 5'h02;   // counter_low_byte
  localparam logic [4:0]  FILE_PTR   = 5'h04;   // indirect_pointer
  localparam logic [2:0]  PTR_FILL   = 3'h7;    // unimplemented bits read high
  localparam logic [4:0]  PTR_RESET  = 5'h00;
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;

  // register bus word offsets (byte addresses)
  localparam logic [4:0]  REG_PTR    = 5'h00;   // indirect_pointer, r/w
  localparam logic [4:0]  REG_PC     = 5'h04;   // program counter, ro
  localparam logic [4:0]  REG_STK1   = 5'h08;   // stack level one, ro
  localparam logic [4:0]  REG_STK2   = 5'h0c;   // stack level two, ro
  localparam logic [4:0]  REG_ACC    = 5'h10;   // accumulator, ro
  localparam logic [4:0]  REG_CFG    = 5'h14;   // bit0 wide stack, r/w
  localparam logic        CFG_RESET  = 1'b1;

  // instruction kinds from the decoder
  typedef enum logic [1:0] {
    OP_SEQ   = 2'h0,
    OP_JUMP  = 2'h1,
    OP_CALL  = 2'h2,
    OP_RETURN = 2'h3
  } op_t;

  // one executed instruction
  typedef struct packed {
    op_t        op;
    logic [8:0] addr;     // jump / call target field
    logic [7:0] literal;  // return_with_literal operand
  } instr_t;

  // data file access from the decoder
  typedef struct packed {
    logic       wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } file_req_t;

  // bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_st_t;

endpackage

// file: verif/pc_stack_indirect_addr_test.sv
`timescale 1ns/1ps
`default_nettype none
module pc_stack_indirect_addr_test
  import pc_stack_pkg::*;
;
  logic        clk_in;            // core clock
  logic        rst_in;            // sync reset
  logic        step_in;           // instruction strobe
  instr_t      instr_in;          // decoded instruction
  file_req_t   file_in;           // file access
  logic [7:0]  file_rdata_out;    // file read data
  logic [8:0]  pc_out;            // program counter
  logic [7:0]  acc_out;           // accumulator
  logic [4:0]  avs_address_in;    // bus address
  logic        avs_read_in;       // bus read
  logic        avs_write_in;      // bus write
  logic [31:0] avs_writedata_in;  // bus write data
  logic [31:0] avs_readdata_out;  // bus read data
  logic        avs_waitrequest_out;
  logic [31:0] rd;                // last bus read
  logic [7:0]  fd;                // last file read
  int          n_mismatch;        // mismatches seen
  int          check_count;       // compares made

  pc_stack_indirect_addr u_pc_stack_indirect_addr (.clk_in(clk_in), .rst_in(rst_in), .step_in(step_in),
    .instr_in(instr_in), .file_in(file_in), .file_rdata_out(file_rdata_out), .pc_out(pc_out),
    .acc_out(acc_out), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hf),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out));

  // 125 mhz clock
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // closing verdict
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one executed instruction, optional file write
  task automatic step(input op_t op, input logic [8:0] a, input logic [7:0] lit,
                      input logic wr, input logic [4:0] fa, input logic [7:0] wd);
    @(posedge clk_in);
    step_in <= 1'b1;
    instr_in <= '{op, a, lit};
    file_in <= '{wr, fa, wd};
    @(posedge clk_in);
    step_in <= 1'b0;
    file_in.wr <= 1'b0;
    #1;
  endtask

  // file read, data one cycle later
  task automatic fread(input logic [4:0] fa);
    @(posedge clk_in);
    file_in.addr <= fa;
    @(posedge clk_in);
    #1;
    fd = file_rdata_out;
  endtask

  // avalon access held until waitrequest low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    int i;
    @(posedge clk_in);
    avs_read_in <= !wr;
    avs_write_in <= wr;
    avs_address_in <= a;
    avs_writedata_in <= wd;
    for (i = 0; i < 20; i++) begin
      @(negedge clk_in);
      if (avs_waitrequest_out === 1'b0) break;
    end
    if (i == 20) begin
      n_mismatch++;
      stop_test();
    end
    @(posedge clk_in);
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  // reset state, wrap, increment, unmapped read
  task automatic t_reset();
    chk(32'(pc_out), 32'h1ff);
    bus(1'b0, REG_PTR, 32'h0);
    chk(rd, 32'he0);
    bus(1'b0, 5'h18, 32'h0);
    chk(rd, 32'h0);
    step(OP_SEQ, 9'h0, 8'h0, 1'b0, 5'h0, 8'h0);
    chk(32'(pc_out), 32'h000);
    step(OP_SEQ, 9'h0, 8'h0, 1'b0, 5'h0, 8'h0);
    chk(32'(pc_out), 32'h001);
  endtask

  // jump, three calls, three returns
  task automatic t_stack();
    step(OP_JUMP, 9'h1a5, 8'h0, 1'b0, 5'h0, 8'h0);
    chk(32'(pc_out), 32'h1a5);
    step(OP_CALL, 9'h1a5, 8'h0, 1'b0, 5'h0, 8'h0);
    chk(32'(pc_out), 32'h0a5);
    bus(1'b0, REG_STK1, 32'h0);
    chk(rd, 32'h1a6);
    step(OP_CALL, 9'h033, 8'h0, 1'b0, 5'h0, 8'h0);
    step(OP_CALL, 9'h044, 8'h0, 1'b0, 5'h0, 8'h0);
    bus(1'b0, REG_STK2, 32'h0);
    chk(rd, 32'h0a6);
    step(OP_RETURN, 9'h0, 8'h5a, 1'b0, 5'h0, 8'h0);
    chk(32'(pc_out), 32'h034);
    chk(32'(acc_out), 32'h5a);
    step(OP_RETURN, 9'h0, 8'h00, 1'b0, 5'h0, 8'h0);
    step(OP_RETURN, 9'h0, 8'h00, 1'b0, 5'h0, 8'h0);
    chk(32'(pc_out), 32'h0a6);
  endtask

  // narrow stack drops bit 8, low byte write jumps
  task automatic t_narrow();
    bus(1'b1, REG_CFG, 32'h0);
    step(OP_JUMP, 9'h1f0, 8'h0, 1'b0, 5'h0, 8'h0);
    step(OP_CALL, 9'h010, 8'h0, 1'b0, 5'h0, 8'h0);
    bus(1'b0, REG_STK1, 32'h0);
    chk(rd, 32'h0f1);
    bus(1'b1, REG_CFG, 32'h1);
    step(OP_JUMP, 9'h1f0, 8'h0, 1'b0, 5'h0, 8'h0);
    step(OP_SEQ, 9'h0, 8'h0, 1'b1, FILE_LOW, 8'h37);
    chk(32'(pc_out), 32'h037);
  endtask

  // pointer and indirect port
  task automatic t_indirect();
    step(OP_SEQ, 9'h0, 8'h0, 1'b1, FILE_PTR, 8'h09);
    step(OP_SEQ, 9'h0, 8'h0, 1'b1, 5'h09, 8'h10);
    fread(FILE_IND);
    chk(32'(fd), 32'h10);
    step(OP_SEQ, 9'h0, 8'h0, 1'b1, FILE_PTR, 8'h00);
    step(OP_SEQ, 9'h0, 8'h0, 1'b1, FILE_IND, 8'h55);
    fread(FILE_IND);
    chk(32'(fd), 32'h00);
    fread(5'h09);
    chk(32'(fd), 32'h10);
    step(OP_SEQ, 9'h0, 8'h0, 1'b1, FILE_PTR, 8'h3f);
    fread(FILE_PTR);
    chk(32'(fd), 32'hff);
    bus(1'b0, REG_PTR, 32'h0);
    chk(rd, 32'hff);
  endtask

  // main sequence
  initial begin
    n_mismatch = 0;
    check_count = 0;
    rst_in = 1'b1;
    step_in = 1'b0;
    instr_in = '0;
    file_in = '0;
    avs_address_in = 5'h00;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    t_reset();
    t_stack();
    t_narrow();
    t_indirect();
    stop_test();
  end
endmodule
`default_nettype wire
